/* core/memory_word_loader.sv */
// Steers memory data writes from the start to the end address of a profile.
// Assumes one write strobe per word from the serial port.
`timescale 1ns/10ps
module memory_word_loader
  import profile_bank_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic word_write,
  input wire logic [31:0] word_data,
  input wire logic restart,
  input wire logic [9:0] start_addr,
  input wire logic [9:0] end_addr,
  output logic wr_en,
  output logic [9:0] wr_addr,
  output logic [31:0] wr_data
);

  logic armed_reg, armed_next;
  logic en_reg, en_next;
  logic [9:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;

  // ----------------------------------------
  // Word sequence
  // ----------------------------------------
  always_comb begin
    armed_next = restart ? 1'b0 : armed_reg;
    en_next = word_write;
    addr_next = addr_reg;
    data_next = word_write ? word_data : data_reg;
    if (word_write) begin
      addr_next = armed_reg ? addr_reg + 10'h001 : start_addr;
      armed_next = (addr_next != end_addr);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
      en_reg <= 1'b0;
      addr_reg <= 10'h000;
      data_reg <= 32'h0000_0000;
    end else begin
      armed_reg <= armed_next;
      en_reg <= en_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  assign wr_en = en_reg;
  assign wr_addr = addr_reg;
  assign wr_data = data_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_RUN_START: assert property (word_write && !armed_reg |=> wr_en && wr_addr == $past(start_addr))
    else $error("memory word run did not begin at start address");
  AST_RUN_END: assert property (wr_en && wr_addr == end_addr && $stable(end_addr) && !word_write |=> !armed_reg)
    else $error("memory word run did not close at end address");
  COV_RUN: cover property (word_write && armed_reg ##1 wr_en);

endmodule

/* core/profile_bank_map.svh */
// Constants of the profile and ramp-rate register bank.
// Assumes an 8-bit serial instruction address and 64-bit write data from the port.
`ifndef PROFILE_BANK_MAP_SVH
`define PROFILE_BANK_MAP_SVH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define ADDR_RAMP_RATE 8'h0d
`define ADDR_PROFILE_FIRST 8'h0e
`define ADDR_PROFILE_LAST 8'h15
`define ADDR_MEMORY_DATA 8'h16

// ----------------------------------------
// Writable bit masks, reset values, slot count and memory depth
// ----------------------------------------
`define TONE_PROFILE_MASK 64'h3fff_ffff_ffff_ffff
`define MEMORY_PROFILE_MASK 64'h00ff_ffff_c0ff_c02f
`define RAMP_RATE_MASK 32'hffff_ffff
`define PROFILE_RESET 64'h0000_0000_0000_0000
`define RAMP_RATE_RESET 32'h0000_0000
`define PROFILE_COUNT 8
`define MEMORY_DEPTH 1024

`endif

/* core/profile_bank_pkg.sv */
// Types of the profile and ramp-rate register bank.
// Assumes the map header is compiled alongside.
package profile_bank_pkg;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] down_interval;
    logic [15:0] up_interval;
  } ramp_rate_type;

  typedef struct packed {
    logic [1:0] unused;
    logic [13:0] amplitude;
    logic [15:0] phase;
    logic [31:0] frequency;
  } tone_profile_type;

  typedef struct packed {
    logic [7:0] unused_high;
    logic [15:0] step_interval;
    logic [9:0] end_addr;
    logic [5:0] unused_mid;
    logic [9:0] start_addr;
    logic [7:0] unused_low;
    logic no_dwell;
    logic unused_bit;
    logic zero_cross;
    logic [2:0] mode;
  } memory_profile_type;

  typedef enum logic [2:0] {
    PLAY_IDLE = 3'b001,
    PLAY_RUN = 3'b010,
    PLAY_HALT = 3'b100
  } playback_state_type;

endpackage

/* core/ramp_slope_timer.sv */
// Paces the digital ramp steps from the ramp rate register.
// Assumes enable and direction are synchronous to core_clk.
`timescale 1ns/10ps
module ramp_slope_timer
  import profile_bank_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic descending,
  input wire ramp_rate_type rate,
  output logic step_pulse
);

  logic [15:0] count_reg, count_next;
  logic step_reg, step_next;
  logic [15:0] interval;

  // ----------------------------------------
  // Interval count
  // ----------------------------------------
  always_comb begin
    interval = descending ? rate.down_interval : rate.up_interval;
    count_next = count_reg + 16'h0001;
    step_next = 1'b0;
    if (!enable) begin
      count_next = 16'h0000;
    end else if (count_next >= interval) begin
      count_next = 16'h0000;
      step_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 16'h0000;
      step_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      step_reg <= step_next;
    end
  end

  assign step_pulse = step_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_DOWN_PACE: assert property (enable && descending && rate.down_interval == 16'h0003 && count_reg == 16'h0000
      ##1 (enable && descending && $stable(rate)) [*2] |=> step_reg)
    else $error("decrement step not paced by upper interval");
  AST_UP_PACE: assert property (enable && !descending && rate.up_interval == 16'h0004 && count_reg == 16'h0000
      ##1 (enable && !descending && $stable(rate)) [*2] |=> !step_reg)
    else $error("increment step came before lower interval");
  COV_STEP: cover property (enable ##1 step_reg);

endmodule

/* core/synth_profile_register_bank.sv */
// Profile slots, ramp rate register and memory data port of the synthesizer.
// Assumes the serial port hands over whole registers as one-cycle strobes.
`timescale 1ns/10ps
`include "profile_bank_map.svh"
module synth_profile_register_bank
  import profile_bank_pkg::*;
#(
  parameter int PROFILES = `PROFILE_COUNT
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [63:0] cfg_wdata,
  output logic [63:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic memory_enable,
  input wire logic [3:0] internal_profile_ctl,
  input wire logic ramp_enable,
  input wire logic parallel_port_enable,
  input wire logic ramp_descending,
  input wire logic memory_ramp_up,
  input wire logic memory_direct_switch,
  input wire logic playback_start,
  input wire logic [2:0] profile_pins,
  output logic [2:0] active_profile,
  output logic tone_mode,
  output logic memory_mode,
  output logic [13:0] output_amplitude_scale,
  output logic [15:0] phase_offset_value,
  output logic [31:0] frequency_increment_word,
  output logic ramp_step,
  output logic zero_cross_enable,
  output logic [2:0] memory_mode_select,
  output logic [9:0] playback_addr,
  output logic playback_busy,
  output logic mem_wr_en,
  output logic [9:0] mem_wr_addr,
  output logic [31:0] mem_wr_data
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (PROFILES != 8) begin : gen_profile_check
    $error("profile slot count must be eight");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_profile(input logic [7:0] addr);
    return (addr >= `ADDR_PROFILE_FIRST) && (addr <= `ADDR_PROFILE_LAST);
  endfunction

  function automatic logic [2:0] slot_of(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `ADDR_PROFILE_FIRST;
    return diff[2:0];
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [63:0] profile_reg [PROFILES];
  logic [63:0] profile_next [PROFILES];
  ramp_rate_type ramp_rate_reg, ramp_rate_next;
  logic [63:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic mem_view, tone_view;
  logic [63:0] write_mask;

  always_comb begin
    mem_view = memory_enable;
    tone_view = !memory_enable && !ramp_enable && !parallel_port_enable;
    write_mask = mem_view ? `MEMORY_PROFILE_MASK : `TONE_PROFILE_MASK;
    for (int i = 0; i < PROFILES; i++) begin
      profile_next[i] = profile_reg[i];
    end
    ramp_rate_next = ramp_rate_reg;
    if (cfg_wr && is_profile(cfg_addr)) begin
      profile_next[slot_of(cfg_addr)] = cfg_wdata & write_mask;
    end
    if (cfg_wr && cfg_addr == `ADDR_RAMP_RATE) begin
      ramp_rate_next = cfg_wdata[31:0] & `RAMP_RATE_MASK;
    end
    rvalid_next = cfg_rd;
    rdata_next = rdata_reg;
    if (cfg_rd) begin
      if (is_profile(cfg_addr)) begin
        rdata_next = profile_reg[slot_of(cfg_addr)] & write_mask;
      end else if (cfg_addr == `ADDR_RAMP_RATE) begin
        rdata_next = {32'h0000_0000, ramp_rate_reg};
      end else begin
        rdata_next = 64'h0000_0000_0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PROFILES; i++) begin
        profile_reg[i] <= `PROFILE_RESET;
      end
      ramp_rate_reg <= `RAMP_RATE_RESET;
      rdata_reg <= 64'h0000_0000_0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      for (int i = 0; i < PROFILES; i++) begin
        profile_reg[i] <= profile_next[i];
      end
      ramp_rate_reg <= ramp_rate_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------
  // Active profile and playback
  // ----------------------------------------
  playback_state_type state_reg, state_next;
  logic [2:0] prof_reg, prof_next;
  logic [9:0] paddr_reg, paddr_next;
  logic [15:0] pcount_reg, pcount_next;
  logic auto_reg, auto_next;
  logic auto_mode, advance;
  logic [2:0] auto_limit;
  tone_profile_type tone_sel;
  memory_profile_type mem_sel;
  memory_profile_type adv_sel;

  always_comb begin
    auto_mode = memory_enable && internal_profile_ctl != 4'h0;
    auto_limit = internal_profile_ctl[3] ? 3'h7 : internal_profile_ctl[2:0];
    tone_sel = profile_reg[prof_reg];
    mem_sel = profile_reg[prof_reg];
    adv_sel = mem_sel;
    state_next = state_reg;
    paddr_next = paddr_reg;
    pcount_next = pcount_reg;
    advance = 1'b0;
    auto_next = auto_mode;
    prof_next = profile_pins;
    if (auto_mode) begin
      prof_next = auto_reg ? prof_reg : 3'h0;
    end
    unique case (state_reg)
      PLAY_IDLE, PLAY_HALT: begin
        if (mem_view && playback_start) begin
          state_next = PLAY_RUN;
          paddr_next = mem_sel.start_addr;
          pcount_next = 16'h0000;
        end
      end
      PLAY_RUN: begin
        pcount_next = pcount_reg + 16'h0001;
        if (!mem_view) begin
          state_next = PLAY_IDLE;
        end else if (pcount_next >= mem_sel.step_interval) begin
          pcount_next = 16'h0000;
          if (paddr_reg == mem_sel.end_addr) begin
            state_next = PLAY_HALT;
            if (memory_ramp_up && mem_sel.no_dwell) begin
              paddr_next = mem_sel.start_addr;
            end
            advance = auto_mode && auto_reg;
          end else begin
            paddr_next = paddr_reg + 10'h001;
          end
        end
      end
      default: begin
        state_next = PLAY_IDLE;
      end
    endcase
    if (advance) begin
      prof_next = (prof_reg == auto_limit) ? 3'h0 : prof_reg + 3'h1;
      state_next = PLAY_RUN;
      adv_sel = profile_reg[prof_next];
      paddr_next = adv_sel.start_addr;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= PLAY_IDLE;
      prof_reg <= 3'h0;
      paddr_reg <= 10'h000;
      pcount_reg <= 16'h0000;
      auto_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      prof_reg <= prof_next;
      paddr_reg <= paddr_next;
      pcount_reg <= pcount_next;
      auto_reg <= auto_next;
    end
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  logic tone_reg, mem_reg, zc_reg;
  logic [13:0] amp_reg;
  logic [15:0] phase_reg;
  logic [31:0] freq_reg;
  logic [2:0] msel_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tone_reg <= 1'b0;
      mem_reg <= 1'b0;
      zc_reg <= 1'b0;
      amp_reg <= 14'h0000;
      phase_reg <= 16'h0000;
      freq_reg <= 32'h0000_0000;
      msel_reg <= 3'h0;
    end else begin
      tone_reg <= tone_view;
      mem_reg <= mem_view;
      zc_reg <= mem_view && memory_direct_switch && mem_sel.zero_cross;
      amp_reg <= tone_sel.amplitude;
      phase_reg <= tone_sel.phase;
      freq_reg <= tone_sel.frequency;
      msel_reg <= mem_sel.mode;
    end
  end

  ramp_slope_timer u_ramp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(ramp_enable),
    .descending(ramp_descending),
    .rate(ramp_rate_reg),
    .step_pulse(ramp_step)
  );

  memory_word_loader u_loader (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .word_write(cfg_wr && cfg_addr == `ADDR_MEMORY_DATA),
    .word_data(cfg_wdata[31:0]),
    .restart(cfg_wr && is_profile(cfg_addr)),
    .start_addr(mem_sel.start_addr),
    .end_addr(mem_sel.end_addr),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data)
  );

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  assign active_profile = prof_reg;
  assign tone_mode = tone_reg;
  assign memory_mode = mem_reg;
  assign output_amplitude_scale = amp_reg;
  assign phase_offset_value = phase_reg;
  assign frequency_increment_word = freq_reg;
  assign zero_cross_enable = zc_reg;
  assign memory_mode_select = msel_reg;
  assign playback_addr = paddr_reg;
  // Run bit of the one-hot state register
  assign playback_busy = state_reg[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_RAMP_GATE: assert property (!ramp_enable |=> !ramp_step)
    else $error("ramp stepped while ramp disabled");
  AST_SLOT_WRITE: assert property (cfg_wr && cfg_addr == `ADDR_PROFILE_LAST ##1 cfg_rd && cfg_addr == `ADDR_PROFILE_LAST
      && $stable(write_mask) |=> cfg_rvalid && cfg_rdata == ($past(cfg_wdata, 2) & $past(write_mask)))
    else $error("last profile slot did not hold its write");
  AST_MEM_MODE: assert property (memory_enable |=> memory_mode && !tone_mode)
    else $error("memory enable did not select memory profiles");
  AST_TONE_MODE: assert property (tone_mode |-> $past(!memory_enable && !ramp_enable && !parallel_port_enable))
    else $error("tone profiles active with a blocking mode set");
  AST_PIN_SELECT: assert property (!auto_mode |=> active_profile == $past(profile_pins))
    else $error("active profile does not follow the pins");
  AST_AUTO_HOLD: assert property (auto_mode && auto_reg && !advance |=> $stable(active_profile))
    else $error("pins moved the profile in internal control");
  AST_TONE_AMP: assert property (1'b1 |=> output_amplitude_scale == $past(profile_reg[prof_reg][61:48]))
    else $error("amplitude not taken from active profile");
  AST_NO_DWELL: assert property (state_reg == PLAY_RUN && mem_view && memory_ramp_up && mem_sel.no_dwell && !advance
      && paddr_reg == mem_sel.end_addr && pcount_reg + 16'h0001 >= mem_sel.step_interval
      |=> state_reg == PLAY_HALT && playback_addr == $past(mem_sel.start_addr))
    else $error("no-dwell did not return to start and halt");
  AST_STEP_ADDR: assert property (state_reg == PLAY_RUN && mem_view && !advance && paddr_reg != mem_sel.end_addr
      && pcount_reg + 16'h0001 >= mem_sel.step_interval |=> playback_addr == $past(paddr_reg) + 10'h001)
    else $error("playback address did not step after its interval");
  AST_END_HALT: assert property (state_reg == PLAY_HALT && !playback_start && !auto_mode |=> $stable(playback_addr))
    else $error("playback moved after halting");
  AST_ZERO_CROSS: assert property (!memory_direct_switch |=> !zero_cross_enable)
    else $error("zero crossing outside direct switch");
  AST_OPEN_BITS: assert property (cfg_rvalid |-> cfg_rdata[63:62] == 2'b00)
    else $error("unused bits read as one");

  COV_AUTO: cover property (advance);
  COV_DWELL: cover property (state_reg == PLAY_RUN ##1 state_reg == PLAY_HALT);
  COV_TONE: cover property (tone_mode && cfg_rvalid);

endmodule

/* testbench/host_port_model.sv */
// Host side of the profile bank: register strobes on the serial port and the profile pins.
// Assumes each task is entered at a falling edge of core_clk.
`timescale 1ns/10ps
module host_port_model (
  input wire logic core_clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [63:0] cfg_wdata,
  input wire logic [63:0] cfg_rdata,
  input wire logic cfg_rvalid,
  output logic [2:0] profile_pins
);
  // ----------------------------------------
  // Idle state
  // ----------------------------------------
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'hff;
    cfg_wdata = 64'h0;
    profile_pins = 3'h0;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // One idle cycle, then a whole register per strobe; released data shows a changed pattern
  task automatic write_reg(input logic [7:0] addr, input logic [63:0] data);
    @(negedge core_clk);
    cfg_addr = addr;
    cfg_wdata = data;
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~data;
  endtask

  // One memory word per strobe in bits 31:0
  task automatic write_word(input logic [31:0] word);
    write_reg(8'h16, {32'hffff_ffff, word});
  endtask

  // Strobe, take the answer while it stands, then one idle cycle
  task automatic read_reg(input logic [7:0] addr, output logic [63:0] data, output logic valid);
    cfg_addr = addr;
    cfg_rd = 1'b1;
    @(negedge core_clk);
    valid = cfg_rvalid;
    data = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_addr = ~addr;
    @(negedge core_clk);
  endtask

  // Profile pins held as a level
  task automatic set_pins(input logic [2:0] sel);
    profile_pins = sel;
  endtask
endmodule

/* testbench/synth_profile_register_bank_tb_top.sv */
// Self-checking bench of the profile and ramp-rate register bank.
// Assumes the host model drives the serial port and the pins at falling edges.
`timescale 1ns/10ps
`include "profile_bank_map.svh"
module synth_profile_register_bank_tb_top;
  logic core_clk, sys_rst, cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr;
  logic [63:0] cfg_wdata, cfg_rdata, rd_data;
  logic memory_enable, ramp_enable, parallel_port_enable, ramp_descending;
  logic memory_ramp_up, memory_direct_switch, playback_start, tone_mode, memory_mode;
  logic ramp_step, zero_cross_enable, playback_busy, mem_wr_en, rd_ok;
  logic [3:0] internal_profile_ctl;
  logic [2:0] profile_pins, active_profile, memory_mode_select;
  logic [13:0] output_amplitude_scale;
  logic [15:0] phase_offset_value;
  logic [31:0] frequency_increment_word, mem_wr_data;
  logic [9:0] playback_addr, mem_wr_addr;
  int miscompares = 0;
  int checked = 0;

  host_port_model host_u (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .profile_pins(profile_pins));

  synth_profile_register_bank #(.PROFILES(8)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .memory_enable(memory_enable), .internal_profile_ctl(internal_profile_ctl),
    .ramp_enable(ramp_enable), .parallel_port_enable(parallel_port_enable),
    .ramp_descending(ramp_descending), .memory_ramp_up(memory_ramp_up),
    .memory_direct_switch(memory_direct_switch), .playback_start(playback_start),
    .profile_pins(profile_pins), .active_profile(active_profile), .tone_mode(tone_mode),
    .memory_mode(memory_mode), .output_amplitude_scale(output_amplitude_scale),
    .phase_offset_value(phase_offset_value), .frequency_increment_word(frequency_increment_word),
    .ramp_step(ramp_step), .zero_cross_enable(zero_cross_enable), .memory_mode_select(memory_mode_select),
    .playback_addr(playback_addr), .playback_busy(playback_busy), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic read_check(input string what, input logic [7:0] addr, input logic [63:0] exp);
    host_u.read_reg(addr, rd_data, rd_ok);
    check({what, " valid"}, {63'h0, rd_ok}, 64'h1);
    check(what, rd_data, exp);
  endtask

  function automatic logic [9:0] probe(input int sel);
    case (sel)
      0: probe = {9'h0, ramp_step};
      1: probe = {9'h0, playback_busy};
      default: probe = {7'h0, active_profile};
    endcase
  endfunction

  // Bounded wait; n counts the cycles spent
  task automatic wait_for(input int sel, input logic [9:0] val, output int n);
    n = 0;
    while (probe(sel) !== val) begin
      cycles(1);
      n++;
      if (n > 500) begin
        miscompares++;
        wrap_up();
      end
    end
  endtask

  function automatic logic [63:0] mprof(input logic [15:0] step, input logic [9:0] last,
      input logic [9:0] first, input logic nd, input logic zc, input logic [2:0] mode);
    mprof = {8'h0, step, last, 6'h0, first, 8'h0, nd, 1'b0, zc, mode};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic [63:0] tone;
    sys_rst = 1'b1;
    {memory_enable, ramp_enable, parallel_port_enable, ramp_descending} = 4'h0;
    {memory_ramp_up, memory_direct_switch, playback_start} = 3'h0;
    internal_profile_ctl = 4'h0;
    cycles(4);
    sys_rst = 1'b0;
    cycles(1);
    read_check("ramp rate reset", `ADDR_RAMP_RATE, 64'h0);
    read_check("profile reset", `ADDR_PROFILE_FIRST, 64'h0);
    host_u.write_reg(8'h17, 64'hffff);
    read_check("unmapped", 8'h17, 64'h0);
    check("tone mode", {63'h0, tone_mode}, 64'h1);
    check("memory mode", {63'h0, memory_mode}, 64'h0);
    // Tone slots: write all eight, read back masked, select by pins
    for (int i = 0; i < 8; i++) begin
      host_u.write_reg(8'h0e + 8'(i), {2'b11, 14'h1000 + 14'(i), 16'h2000 + 16'(i), 32'h3000_0000 + 32'(i)});
    end
    for (int i = 7; i >= 0; i--) begin
      tone = {2'b11, 14'h1000 + 14'(i), 16'h2000 + 16'(i), 32'h3000_0000 + 32'(i)};
      read_check("tone slot", 8'h0e + 8'(i), tone & `TONE_PROFILE_MASK);
      host_u.set_pins(3'(i));
      cycles(3);
      check("active slot", 64'(active_profile), 64'(i));
      check("amplitude", 64'(output_amplitude_scale), 64'(tone[61:48]));
      check("phase", 64'(phase_offset_value), 64'(tone[47:32]));
      check("frequency", 64'(frequency_increment_word), 64'(tone[31:0]));
    end
    ramp_enable = 1'b1;
    cycles(2);
    check("tone off by ramp", {63'h0, tone_mode}, 64'h0);
    ramp_enable = 1'b0;
    parallel_port_enable = 1'b1;
    cycles(2);
    check("tone off by parallel", {63'h0, tone_mode}, 64'h0);
    parallel_port_enable = 1'b0;
    // Ramp pacing
    host_u.write_reg(`ADDR_RAMP_RATE, 64'hffff_ffff_0003_0004);
    read_check("ramp rate", `ADDR_RAMP_RATE, 64'h0000_0000_0003_0004);
    ramp_enable = 1'b1;
    wait_for(0, 10'h1, n);
    cycles(1);
    wait_for(0, 10'h1, n);
    check("up interval", 64'(n + 1), 64'h4);
    ramp_descending = 1'b1;
    cycles(8);
    wait_for(0, 10'h1, n);
    cycles(1);
    wait_for(0, 10'h1, n);
    check("down interval", 64'(n + 1), 64'h3);
    ramp_enable = 1'b0;
    cycles(2);
    n = 0;
    repeat (12) begin
      n += int'(ramp_step === 1'b1);
      cycles(1);
    end
    check("no steps when off", 64'(n), 64'h0);
    // Memory profiles
    memory_enable = 1'b1;
    cycles(2);
    check("memory mode on", {62'h0, memory_mode, tone_mode}, 64'h2);
    host_u.write_reg(`ADDR_PROFILE_FIRST, 64'hffff_ffff_ffff_ffff);
    read_check("memory slot", `ADDR_PROFILE_FIRST, `MEMORY_PROFILE_MASK);
    host_u.write_reg(`ADDR_PROFILE_FIRST, mprof(16'h2, 10'h4, 10'h2, 1'b0, 1'b1, 3'h5));
    host_u.write_reg(8'h0f, mprof(16'h1, 10'h1, 10'h0, 1'b0, 1'b0, 3'h0));
    host_u.set_pins(3'h0);
    memory_direct_switch = 1'b1;
    cycles(3);
    check("mode select", 64'(memory_mode_select), 64'h5);
    check("zero cross on", {63'h0, zero_cross_enable}, 64'h1);
    memory_direct_switch = 1'b0;
    cycles(2);
    check("zero cross off", {63'h0, zero_cross_enable}, 64'h0);
    // Word run from start 2 to end 4, then back to start
    for (int k = 0; k < 4; k++) begin
      host_u.write_word(32'ha5a5_0000 + 32'(k));
      check("word strobe", {63'h0, mem_wr_en}, 64'h1);
      check("word addr", 64'(mem_wr_addr), 64'(2 + k % 3));
      check("word data", 64'(mem_wr_data), 64'(32'ha5a5_0000 + 32'(k)));
    end
    // Ramp-up playback with and without no-dwell
    memory_ramp_up = 1'b1;
    for (int nd = 0; nd < 2; nd++) begin
      host_u.write_reg(`ADDR_PROFILE_FIRST, mprof(16'h2, 10'h4, 10'h2, 1'(nd), 1'b1, 3'h5));
      playback_start = 1'b1;
      cycles(1);
      playback_start = 1'b0;
      cycles(1);
      check("playback busy", {63'h0, playback_busy}, 64'h1);
      check("playback start", 64'(playback_addr), 64'h2);
      wait_for(1, 10'h0, n);
      check("playback halt", 64'(playback_addr), nd == 1 ? 64'h2 : 64'h4);
    end
    // Internal profile control ignores the pins
    host_u.set_pins(3'h5);
    internal_profile_ctl = 4'h2;
    playback_start = 1'b1;
    cycles(1);
    playback_start = 1'b0;
    cycles(2);
    check("auto first slot", 64'(active_profile), 64'h0);
    wait_for(2, 10'h1, n);
    check("auto next slot", 64'(active_profile), 64'h1);
    wrap_up();
  end
endmodule
